// *** hw/sram_port_pkg.sv ***
package sram_port_pkg;
  // Clock period in picoseconds (50 MHz)
  localparam int CLK_PERIOD_PS = 20000;
  // Memory geometry
  localparam int ADDR_W = 19;
  localparam int DATA_W = 16;
  // Timing figures in ns
  localparam int T_AA_NS = 55;   // Longest address-to-data time
  localparam int T_RC_NS = 55;   // Read cycle time
  localparam int T_WC_NS = 55;   // Write cycle time
  localparam int T_PWE_NS = 40;  // Write strobe width
  localparam int T_SD_NS = 25;   // Data setup to write end
  localparam int T_HZWE_NS = 20; // Longest time for memory to float after strobe low
  localparam int T_HZOE_NS = 20; // Longest time for memory to float after drive off
  localparam int T_R_NS = 55;    // Recovery after retention
  // Least times rounded up to whole cycles; read access gets one cycle more
  localparam int RD_CYC = (T_AA_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS + 1;
  localparam int WR_CYC = (T_PWE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int HZ_CYC = (T_HZOE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int REC_CYC = (T_R_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int SD_CYC = (T_SD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CNT_W = 4;
  // Controller states
  typedef enum logic [5:0] {
    ST_IDLE = 6'b00_0001,
    ST_READ = 6'b00_0010,
    ST_WSET = 6'b00_0100,
    ST_WRITE = 6'b00_1000,
    ST_END = 6'b01_0000,
    ST_RET = 6'b10_0000
  } state_type;
endpackage : sram_port_pkg

// *** hw/sram_host_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none
module sram_host_ctrl
  import sram_port_pkg::*;
#(
  parameter int AW = sram_port_pkg::ADDR_W,
  parameter int DW = sram_port_pkg::DATA_W
) (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_req,                 // Request strobe
  input wire logic i_we,                  // 1 write, 0 read
  input wire logic [AW-1:0] i_addr,       // Word address
  input wire logic [DW-1:0] i_wdata,      // Write data
  input wire logic [1:0] i_lane_en,       // Bit1 upper, bit0 lower
  input wire logic i_retain,              // Level: request retention standby
  output logic o_ready,                   // Can take a request
  output logic o_rvalid,                  // One-cycle read data pulse
  output logic [DW-1:0] o_rdata,
  output logic o_retained,                // In retention standby
  output logic [AW-1:0] o_mem_addr,
  output logic o_primary_select_n,
  output logic o_secondary_select,
  output logic o_write_strobe_n,
  output logic o_output_drive_n,
  output logic o_upper_lane_enable_n,
  output logic o_lower_lane_enable_n,
  input wire logic [DW-1:0] i_mem_data,
  output logic [DW-1:0] o_mem_data,
  output logic o_mem_data_oe
);
  import sram_port_pkg::*;

  // Reset release synchroniser
  logic rst_s1_r, rst_s2_r;
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end
  wire rst_n = rst_s2_r;

  // Data bus input sync: three stages, taken when second and third agree
  logic [DW-1:0] din1_r, din2_r, din3_r;
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      din1_r <= '0;
      din2_r <= '0;
      din3_r <= '0;
    end else begin
      din1_r <= i_mem_data;
      din2_r <= din1_r;
      din3_r <= din2_r;
    end
  end

  // Controller state
  state_type st_r, st_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;         // Interval counter
  logic [AW-1:0] addr_r, addr_nxt;
  logic [DW-1:0] wdat_r, wdat_nxt;
  logic [1:0] lane_r, lane_nxt;             // Active-high lane enables
  logic [DW-1:0] rdat_r, rdat_nxt;
  logic rv_r, rv_nxt;
  logic sel_r, sel_nxt;                     // Selects asserted
  logic ws_r, ws_nxt;                       // Write strobe asserted
  logic oe_r, oe_nxt;                       // Output drive asserted
  logic dr_r, dr_nxt;                       // Host drives data
  logic rec_r, rec_nxt;                     // Recovery pending

  // Bus bits that belong to the enabled lanes; a disabled lane floats and never settles
  function automatic logic [DW-1:0] lane_mask(input logic [1:0] lanes);
    lane_mask = {{(DW/2){lanes[1]}}, {(DW/2){lanes[0]}}};
  endfunction : lane_mask

  // Next-state logic; every interval is a whole-cycle count
  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    addr_nxt = addr_r;
    wdat_nxt = wdat_r;
    lane_nxt = lane_r;
    rdat_nxt = rdat_r;
    rv_nxt = 1'b0;
    sel_nxt = sel_r;
    ws_nxt = ws_r;
    oe_nxt = oe_r;
    dr_nxt = dr_r;
    rec_nxt = rec_r;
    case (st_r)
      ST_IDLE: begin
        if (cnt_r != '0) begin
          cnt_nxt = cnt_r - 1'b1;           // Recovery or float wait
        end else if (i_retain) begin
          sel_nxt = 1'b0;                   // Deselect first, zero margin
          lane_nxt = 2'b00;
          st_nxt = ST_RET;
        end else if (i_req && i_lane_en != 2'b00) begin
          // Address latched and driven on the same edge that selects go active
          addr_nxt = i_addr;
          wdat_nxt = i_wdata;
          lane_nxt = i_lane_en;
          sel_nxt = 1'b1;
          if (i_we) begin
            oe_nxt = 1'b0;                  // Output drive off before writing
            cnt_nxt = CNT_W'(HZ_CYC);
            st_nxt = ST_WSET;
          end else begin
            oe_nxt = 1'b1;
            cnt_nxt = CNT_W'(RD_CYC + 2);   // Access time plus sync latency
            st_nxt = ST_READ;
          end
        end
      end
      ST_READ: begin
        // Strobe stays high for the whole read
        if (cnt_r != '0) begin
          cnt_nxt = cnt_r - 1'b1;
        end else if (((din2_r ^ din3_r) & lane_mask(lane_r)) == '0) begin
          // Only enabled lanes must agree, or a floating lane would stall the read
          rdat_nxt = din3_r & lane_mask(lane_r); // Sampled well after 55 ns
          rv_nxt = 1'b1;
          sel_nxt = 1'b0;
          oe_nxt = 1'b0;
          lane_nxt = 2'b00;
          cnt_nxt = CNT_W'(HZ_CYC);         // Let the memory float before next use
          st_nxt = ST_IDLE;
        end
      end
      ST_WSET: begin
        // Wait out memory float time before driving the bus
        if (cnt_r != '0) begin
          cnt_nxt = cnt_r - 1'b1;
        end else begin
          dr_nxt = 1'b1;
          ws_nxt = 1'b1;                    // Write begins on full overlap
          cnt_nxt = CNT_W'(WR_CYC);
          st_nxt = ST_WRITE;
        end
      end
      ST_WRITE: begin
        if (cnt_r != '0) begin
          cnt_nxt = cnt_r - 1'b1;           // Strobe width and data setup
        end else begin
          ws_nxt = 1'b0;                    // Strobe is the terminating edge
          st_nxt = ST_END;
        end
      end
      ST_END: begin
        // Address, data and selects held one cycle past the end
        dr_nxt = 1'b0;
        sel_nxt = 1'b0;
        lane_nxt = 2'b00;
        st_nxt = ST_IDLE;
      end
      ST_RET: begin
        if (!i_retain) begin
          cnt_nxt = CNT_W'(REC_CYC);        // Recovery before next access
          rec_nxt = 1'b1;
          st_nxt = ST_IDLE;
        end
      end
      default: begin
        st_nxt = ST_IDLE;
      end
    endcase
    if (st_r == ST_IDLE && cnt_r == '0) begin
      rec_nxt = 1'b0;
    end
  end

  // State registers
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= ST_IDLE;
      cnt_r <= '0;
      addr_r <= '0;
      wdat_r <= '0;
      lane_r <= 2'b00;
      rdat_r <= '0;
      rv_r <= 1'b0;
      sel_r <= 1'b0;
      ws_r <= 1'b0;
      oe_r <= 1'b0;
      dr_r <= 1'b0;
      rec_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      addr_r <= addr_nxt;
      wdat_r <= wdat_nxt;
      lane_r <= lane_nxt;
      rdat_r <= rdat_nxt;
      rv_r <= rv_nxt;
      sel_r <= sel_nxt;
      ws_r <= ws_nxt;
      oe_r <= oe_nxt;
      dr_r <= dr_nxt;
      rec_r <= rec_nxt;
    end
  end

  // Pin drive; idle selects off put the memory in standby
  assign o_mem_addr = addr_r;
  assign o_primary_select_n = ~sel_r;
  assign o_secondary_select = sel_r;
  assign o_write_strobe_n = ~ws_r;
  assign o_output_drive_n = ~oe_r;
  assign o_upper_lane_enable_n = ~lane_r[1];
  assign o_lower_lane_enable_n = ~lane_r[0];
  assign o_mem_data = wdat_r;
  assign o_mem_data_oe = dr_r;
  // No request is taken until the reset release has passed both flops
  assign o_ready = rst_n && (st_r == ST_IDLE) && (cnt_r == '0) && !i_retain;
  assign o_rvalid = rv_r;
  assign o_rdata = rdat_r;
  assign o_retained = (st_r == ST_RET);

  // Checks
  a_strobe_in_read: assert property (@(posedge i_mclk) disable iff (!rst_n)
    st_r == ST_READ |-> !ws_r) else $error("strobe active in read");
  a_no_clash: assert property (@(posedge i_mclk) disable iff (!rst_n)
    dr_r |-> !oe_r) else $error("bus clash with output drive");
  a_write_overlap: assert property (@(posedge i_mclk) disable iff (!rst_n)
    ws_r |-> sel_r && lane_r != 2'b00 && dr_r) else $error("write without overlap");
  a_strobe_width: assert property (@(posedge i_mclk) disable iff (!rst_n)
    $rose(ws_r) |-> ws_r [*3]) else $error("strobe too short");
  a_addr_hold: assert property (@(posedge i_mclk) disable iff (!rst_n)
    $fell(ws_r) |-> $stable(addr_r) && dr_r) else $error("address or data not held");
  a_addr_stable: assert property (@(posedge i_mclk) disable iff (!rst_n)
    sel_r && $past(sel_r) |-> $stable(addr_r)) else $error("address moved");
  a_read_late: assert property (@(posedge i_mclk) disable iff (!rst_n)
    $rose(sel_r) && st_r == ST_READ |-> !rv_r [*4]) else $error("read sampled too early");
  a_retain_desel: assert property (@(posedge i_mclk) disable iff (!rst_n)
    st_r == ST_RET |-> !sel_r && lane_r == 2'b00) else $error("selected in retention");
  a_recover_gap: assert property (@(posedge i_mclk) disable iff (!rst_n)
    $fell(o_retained) |-> !sel_r [*3]) else $error("access inside recovery");
  a_recover_flag: assert property (@(posedge i_mclk) disable iff (!rst_n)
    rec_r |-> !sel_r) else $error("selected while recovering");
  c_read: cover property (@(posedge i_mclk) disable iff (!rst_n) rv_r);
  c_write: cover property (@(posedge i_mclk) disable iff (!rst_n) $fell(ws_r));
  c_retain: cover property (@(posedge i_mclk) disable iff (!rst_n) $fell(o_retained));
endmodule : sram_host_ctrl
`default_nettype wire

// *** verif/sram_dev_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// Behavioural memory on the far side; counts every timing fault it sees
module sram_dev_model (
  input wire logic [18:0] i_addr,
  input wire logic i_primary_select_n,
  input wire logic i_secondary_select,
  input wire logic i_write_strobe_n,
  input wire logic i_output_drive_n,
  input wire logic i_upper_lane_enable_n,
  input wire logic i_lower_lane_enable_n,
  input wire logic [15:0] i_host_data,
  input wire logic i_host_oe,
  output logic [15:0] o_bus,
  output int o_faults
);
  logic [15:0] mem [logic [18:0]]; // Sparse store of the word array
  logic [1:0] lane; // Bit1 upper, bit0 lower, active high
  realtime t_acc, t_dat, t_adr; // Last change of access, data, address
  logic wr_on = 1'b0; // A write really opened; keeps an unknown-to-low start from storing
  assign lane = {!i_upper_lane_enable_n, !i_lower_lane_enable_n};
  wire sel = !i_primary_select_n && i_secondary_select && (lane != 2'h0);
  wire wr_act = sel && !i_write_strobe_n;
  wire rd_act = sel && i_write_strobe_n && !i_output_drive_n;
  initial begin
    o_faults = 0;
    o_bus = 16'h0000;
  end
  // Access timer restarts on address or selection change
  always @(i_addr or rd_act or lane) t_acc = $realtime;
  // Data counts as valid from its last change or from when the host starts driving it
  always @(i_host_data or posedge i_host_oe) t_dat = $realtime;
  always @(posedge wr_act) wr_on = 1'b1;
  // Address must not move inside a write
  always @(i_addr) begin
    if (wr_act) o_faults++;
    t_adr = $realtime;
  end
  // Store enabled bytes at the edge that ends the write
  always @(negedge wr_act) begin
    if (wr_on) begin
      wr_on = 1'b0;
      if ($realtime - t_dat < 25.0 || $realtime - t_adr < 40.0 || !i_host_oe) o_faults++;
      if (!mem.exists(i_addr)) mem[i_addr] = 16'h0000;
      if (lane[0]) mem[i_addr][7:0] = i_host_data[7:0];
      if (lane[1]) mem[i_addr][15:8] = i_host_data[15:8];
    end
  end
  // Resolve the bus each ns; undriven lines keep flipping so stale reads show
  always #1 begin
    if (i_host_oe && rd_act) o_faults++;
    if (i_host_oe) o_bus = i_host_data;
    else begin
      o_bus = ~o_bus;
      for (int b = 0; b < 2; b++)
        if (rd_act && lane[b] && $realtime - t_acc >= 55.0)
          o_bus[b*8 +: 8] = mem.exists(i_addr) ? mem[i_addr][b*8 +: 8] : 8'h00;
    end
  end
endmodule : sram_dev_model
`default_nettype wire

// *** verif/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import sram_port_pkg::*;
`define CHK(a, e, m) begin n_checks++; if ((a) !== (e)) begin mismatches++; \
  $display("CHECK FAILED t=%0t %s", $time, m); end end
  logic i_mclk = 1'b0, i_rst_n = 1'b0, i_req = 1'b0, i_we = 1'b0, i_retain = 1'b0;
  logic [18:0] i_addr = 19'h0_0000;
  logic [15:0] i_wdata = 16'h0000;
  logic [1:0] i_lane_en = 2'h0;
  wire logic o_ready, o_rvalid, o_retained, o_primary_select_n, o_secondary_select;
  wire logic o_write_strobe_n, o_output_drive_n, o_upper_lane_enable_n, o_lower_lane_enable_n;
  wire logic o_mem_data_oe;
  wire logic [18:0] o_mem_addr;
  wire logic [15:0] o_rdata, o_mem_data, i_mem_data;
  int mismatches = 0, n_checks = 0, faults;
  always #10 i_mclk = ~i_mclk;
  sram_host_ctrl i_sram_host_ctrl (.i_mclk, .i_rst_n, .i_req, .i_we, .i_addr, .i_wdata,
    .i_lane_en, .i_retain, .o_ready, .o_rvalid, .o_rdata, .o_retained, .o_mem_addr,
    .o_primary_select_n, .o_secondary_select, .o_write_strobe_n, .o_output_drive_n,
    .o_upper_lane_enable_n, .o_lower_lane_enable_n, .i_mem_data, .o_mem_data, .o_mem_data_oe);
  sram_dev_model i_sram_dev_model (.i_addr(o_mem_addr), .i_primary_select_n(o_primary_select_n),
    .i_secondary_select(o_secondary_select), .i_write_strobe_n(o_write_strobe_n),
    .i_output_drive_n(o_output_drive_n), .i_upper_lane_enable_n(o_upper_lane_enable_n),
    .i_lower_lane_enable_n(o_lower_lane_enable_n), .i_host_data(o_mem_data),
    .i_host_oe(o_mem_data_oe), .o_bus(i_mem_data), .o_faults(faults));
  // Verdict and end of run
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : close_out
  // Bounded wait at falling edges: 0 ready, 1 read pulse, 2 retained
  task automatic wait_hi(input int w);
    int k;
    k = 0;
    while ((w == 0 ? o_ready : w == 1 ? o_rvalid : o_retained) !== 1'b1) begin
      @(negedge i_mclk);
      k++;
      if (k > 60) begin
        mismatches++;
        $display("CHECK FAILED t=%0t wait ran out", $time);
        close_out();
      end
    end
  endtask : wait_hi
  // One request, held until the rising edge that takes it
  task automatic access(input logic we, input logic [18:0] a, input logic [15:0] d,
      input logic [1:0] ln);
    wait_hi(0);
    {i_we, i_addr, i_wdata, i_lane_en, i_req} = {we, a, d, ln, 1'b1};
    @(negedge i_mclk);
    i_req = 1'b0;
  endtask : access
  // Read and compare only the lanes asked for; disabled lanes float
  task automatic rd(input logic [18:0] a, input logic [1:0] ln, input logic [15:0] e);
    logic [15:0] m;
    m = {{8{ln[1]}}, {8{ln[0]}}};
    access(1'b0, a, 16'h0000, ln);
    wait_hi(1);
    `CHK(o_rdata & m, e & m, "read data")
  endtask : rd
  task automatic t_lanes();
    access(1'b1, 19'h1_2345, 16'h1111, 2'h3);
    access(1'b1, 19'h1_2345, 16'hEE77, 2'h1);
    access(1'b1, 19'h1_2345, 16'h9900, 2'h2);
    rd(19'h1_2345, 2'h3, 16'h9977);
    rd(19'h1_2345, 2'h1, 16'h0077);
    rd(19'h1_2345, 2'h2, 16'h9900);
    $display("lane test done");
  endtask : t_lanes
  // Extreme addresses back to back
  task automatic t_bounds();
    access(1'b1, 19'h7_FFFF, 16'hBEEF, 2'h3);
    access(1'b1, 19'h0_0000, 16'h4321, 2'h3);
    rd(19'h7_FFFF, 2'h3, 16'hBEEF);
    rd(19'h0_0000, 2'h3, 16'h4321);
    $display("bounds test done");
  endtask : t_bounds
  // Request with no lane must leave the memory untouched
  task automatic t_refuse();
    access(1'b1, 19'h0_0000, 16'hFFFF, 2'h0);
    repeat (6) begin
      @(negedge i_mclk);
      `CHK({o_write_strobe_n, o_upper_lane_enable_n, o_lower_lane_enable_n}, 3'h7, "idle")
    end
    rd(19'h0_0000, 2'h3, 16'h4321);
    $display("refuse test done");
  endtask : t_refuse
  task automatic t_retain();
    int n;
    i_retain = 1'b1;
    wait_hi(2);
    `CHK({o_primary_select_n, o_secondary_select, o_ready}, 3'h4, "retain pins")
    i_retain = 1'b0;
    n = 0;
    while (o_ready !== 1'b1 && n < 60) begin
      @(negedge i_mclk);
      n++;
    end
    `CHK(n >= REC_CYC, 1'b1, "recovery time")
    `CHK(o_ready, 1'b1, "recovery ended")
    rd(19'h7_FFFF, 2'h3, 16'hBEEF);
    $display("retention test done");
  endtask : t_retain
  initial begin
    repeat (10) @(negedge i_mclk);
    i_rst_n = 1'b1;
    `CHK({o_primary_select_n, o_secondary_select, o_write_strobe_n}, 3'h5, "reset pins")
    t_lanes();
    t_bounds();
    t_refuse();
    t_retain();
    `CHK(faults, 0, "bus timing faults")
    close_out();
  end
endmodule : testbench
`default_nettype wire
